// >>> sim/lwsp_assertions.sv
`timescale 1ns/1ps
module lwsp_assertions (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Command
	input wire logic counter_step_not_load,
	input wire logic store_select_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic clock_gate_n,
	// Data and controls
	input wire logic [lwsp_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe_n,
	input wire logic output_enable_n,
	input wire logic sleep_request,
	input wire logic pipe_bypass_n,
	input wire logic power_down
);
	wire act = !clock_gate_n && !sleep_request;
	wire ld = act && !counter_step_not_load;
	wire sel = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	wire rd = ld && sel && store_select_n;
	wire wr = ld && sel && !store_select_n;
	wire on = !output_enable_n && !sleep_request;
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	oe_float_a: assert property (output_enable_n |-> dq_oe_n) else $error("drive with oe off");
	sleep_float_a: assert property (sleep_request |-> dq_oe_n && power_down) else $error("sleep");
	pd_follow_a: assert property (!sleep_request |-> !power_down) else $error("power down");
	rd_pipe_a: assert property (rd && pipe_bypass_n ##1 act ##1 on |-> !dq_oe_n) else $error("pipe rd");
	rd_flow_a: assert property (rd && !pipe_bypass_n ##1 on |-> !dq_oe_n) else $error("flow rd");
	wr_float_a: assert property (wr && pipe_bypass_n ##1 act |=> dq_oe_n) else $error("write drv");
	desel_float_a: assert property (ld && !sel && pipe_bypass_n ##1 act |=> dq_oe_n) else $error("desel");
	gate_hold_a: assert property (clock_gate_n |=> $stable(dq_out)) else $error("gate moved");
	cover property (rd ##1 wr);
	cover property (wr ##1 rd);
	cover property (clock_gate_n ##1 !dq_oe_n);
endmodule

bind lwsp_top lwsp_assertions lwsp_assertions_inst (.mclk, .arst_n, .counter_step_not_load, .store_select_n,
	.chip_select_one_n, .chip_select_two, .chip_select_three_n, .clock_gate_n, .dq_out, .dq_oe_n,
	.output_enable_n, .sleep_request, .pipe_bypass_n, .power_down);

// >>> sim/lwsp_ctl_model.sv
`timescale 1ns/1ps
module lwsp_ctl_model (
	// Bus pins
	input wire logic [lwsp_pkg::DATA_W-1:0] dq_out,
	input wire logic dq_oe_n,
	output logic [lwsp_pkg::DATA_W-1:0] dq_in,
	// Controller side
	input wire logic drv,
	input wire logic [lwsp_pkg::DATA_W-1:0] wdata
);
	logic [lwsp_pkg::DATA_W-1:0] last_q = 36'h0_0000_0000;
	// No pull on the bus: a floating bus shows the inverse of its last value
	assign dq_in = !dq_oe_n ? dq_out : drv ? wdata : ~last_q;
	always @(dq_in) if (!dq_oe_n || drv) last_q = dq_in;
endmodule

// >>> sim/lwsp_top_tb_top.sv
`timescale 1ns/1ps
module lwsp_top_tb_top;
	logic mclk = 1'b0, arst_n = 1'b0, counter_step_not_load = 1'b0, store_select_n = 1'b1;
	logic chip_select_one_n = 1'b1, chip_select_two = 1'b0, chip_select_three_n = 1'b1, clock_gate_n = 1'b0;
	logic output_enable_n = 1'b0, sleep_request = 1'b0, pipe_bypass_n = 1'b1, linear_order_n = 1'b0, drv = 1'b0;
	logic [lwsp_pkg::UPPER_W-1:0] addr_upper = 16'h0000, bu;
	logic [1:0] burst_start_bits = 2'h0, bs, bk;
	logic [3:0] lane_n = 4'hF;
	logic [lwsp_pkg::DATA_W-1:0] dq_in, dq_out, wdata = 36'h0_0000_0000;
	logic dq_oe_n, power_down;
	logic [35:0] mem [int], ed [int], wd [int];
	int failures = 0, n_tests = 0, cyc = 0;
	lwsp_top lwsp_top_inst (.mclk, .arst_n, .addr_upper, .burst_start_bits, .counter_step_not_load,
		.store_select_n, .chip_select_one_n, .chip_select_two, .chip_select_three_n, .clock_gate_n,
		.lane0_write_n(lane_n[0]), .lane1_write_n(lane_n[1]), .lane2_write_n(lane_n[2]),
		.lane3_write_n(lane_n[3]), .dq_in, .dq_out, .dq_oe_n, .output_enable_n, .sleep_request,
		.pipe_bypass_n, .linear_order_n, .power_down);
	lwsp_ctl_model lwsp_ctl_model_inst (.dq_out, .dq_oe_n, .dq_in, .drv, .wdata);
	always #50 mclk = ~mclk;
	// Count only edges the device acts on, so stalls shift no expectation
	always @(posedge mclk) if (!clock_gate_n && !sleep_request) cyc <= cyc + 1;
	always @(posedge mclk) begin
		#1;
		drv = wd.exists(cyc);
		wdata = drv ? wd[cyc] : 36'h0_0000_0000;
	end
	always @(negedge mclk) if (ed.exists(cyc)) chk({dq_oe_n, dq_out}, {1'b0, ed[cyc]});
	task chk(input logic [36:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("FAIL %0t got %h want %h", $time, got, exp);
		end
	endtask
	task op(input logic stp, w, input logic [3:0] ln, input logic [17:0] a, input logic [35:0] d);
		int l;
		logic [17:0] ea;
		l = pipe_bypass_n ? lwsp_pkg::PIPE_LATENCY : lwsp_pkg::FLOW_LATENCY;
		if (!stp) {bu, bs, bk} = {a, 2'h0};
		else bk = bk + 2'h1;
		ea = {bu, linear_order_n ? bs ^ bk : bs + bk};
		{counter_step_not_load, store_select_n, lane_n, addr_upper, burst_start_bits} = {stp, !w, ln, a};
		{chip_select_one_n, chip_select_two, chip_select_three_n} = 3'b010;
		if (w) begin
			wd[cyc + l] = d;
			for (int g = 0; g < 4; g++) if (!ln[g]) mem[ea][9*g +: 9] = d[9*g +: 9];
		end else ed[cyc + l] = mem[ea];
		@(posedge mclk);
		#1;
	endtask
	task idle(input logic [2:0] cs, input int n);
		{chip_select_one_n, chip_select_two, chip_select_three_n, counter_step_not_load} = {cs, 1'b0};
		repeat (n) begin
			@(posedge mclk);
			#1;
		end
	endtask
	task gate(input int n);
		clock_gate_n = 1'b1;
		idle({chip_select_one_n, chip_select_two, chip_select_three_n}, n);
		clock_gate_n = 1'b0;
	endtask
	task stop_test();
		$display("checks %0d failures %0d", n_tests, failures);
		if (failures == 0 && n_tests > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	initial begin
		logic [17:0] a;
		repeat (4) @(posedge mclk);
		#1;
		arst_n = 1'b1;
		for (int m = 0; m < 4; m++) begin
			idle(3'b110, 3);
			{pipe_bypass_n, linear_order_n} = 2'(m ^ 2);
			a = {16'(m + 8), 2'(m)};
			for (int k = 0; k < 4; k++) begin
				op(k != 0, 1'b1, 4'h0, k ? ~a : a, 36'h9_1234_5670 + 36'(m * 4 + k));
				if (k == 2) gate(3);
			end
			for (int k = 0; k < 4; k++) begin
				op(k != 0, 1'b0, 4'hF, k ? ~a : a, 36'h0_0000_0000);
				if (k == 1) gate(2);
			end
			for (int g = 0; g < 5; g++) op(1'b0, 1'b1, ~(4'h1 << g), a, 36'hC_3C3C_3C3C + 36'(g));
			idle(3'b000, 1);
			idle(3'b011, 1);
			op(1'b0, 1'b0, 4'hF, a, 36'h0_0000_0000);
			idle(3'b110, 3);
			$display("mode %0d done", m);
		end
		op(1'b0, 1'b0, 4'hF, a, 36'h0_0000_0000);
		ed.delete();
		@(posedge mclk);
		#20;
		chk(37'(dq_oe_n), 37'h0);
		output_enable_n = 1'b1;
		#5;
		chk(37'(dq_oe_n), 37'h1);
		sleep_request = 1'b1;
		#5;
		chk(37'({power_down, dq_oe_n}), 37'h3);
		// Let edges pass in sleep so the sleep checks see clocked cycles too
		output_enable_n = 1'b0;
		repeat (2) @(posedge mclk);
		#1;
		chk(37'({power_down, dq_oe_n}), 37'h3);
		stop_test();
	end
endmodule

// >>> verilog/lwsp_burst_ctr.sv
`timescale 1ns/1ps
module lwsp_burst_ctr (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Control
	input wire logic active,
	input wire logic load,
	input wire logic linear,
	input wire logic [lwsp_pkg::BURST_W-1:0] start,
	// Low address bits for this edge
	output logic [lwsp_pkg::BURST_W-1:0] bits
);

	logic [lwsp_pkg::BURST_W-1:0] start_q;
	logic [lwsp_pkg::BURST_W-1:0] step_q;
	logic [lwsp_pkg::BURST_W-1:0] step_d;
	logic [lwsp_pkg::BURST_W-1:0] lin_bits;
	logic [lwsp_pkg::BURST_W-1:0] ilv_bits;

	// Two-bit step wraps by itself after four addresses
	assign step_d = load ? lwsp_pkg::BURST_RST : step_q + 2'h1;
	assign lin_bits = start_q + step_d;
	assign ilv_bits = start_q ^ step_d;
	assign bits = load ? start : (linear ? lin_bits : ilv_bits);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			start_q <= lwsp_pkg::BURST_RST;
			step_q <= lwsp_pkg::BURST_RST;
		end else if (active) begin
			if (load) begin
				start_q <= start;
			end
			step_q <= step_d;
		end
	end

endmodule

// >>> verilog/lwsp_core.sv
`timescale 1ns/1ps
module lwsp_core (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Read port
	input wire logic rd_en,
	input wire logic [lwsp_pkg::ADDR_W-1:0] rd_addr,
	output logic [lwsp_pkg::DATA_W-1:0] rd_data_q,
	// Write port
	input wire logic wr_en,
	input wire logic [lwsp_pkg::ADDR_W-1:0] wr_addr,
	input wire logic [lwsp_pkg::LANES-1:0] wr_lane_n,
	input wire logic [lwsp_pkg::DATA_W-1:0] wr_data
);

	// Each lane of nine bits has its own array and its own low-active select,
	// so no two processes ever write the same storage
	for (genvar g = 0; g < lwsp_pkg::LANES; g++) begin : g_lane
		localparam int LO = g * lwsp_pkg::LANE_W;
		logic [lwsp_pkg::LANE_W-1:0] mem [lwsp_pkg::DEPTH];

		always_ff @(posedge mclk) begin
			if (wr_en && !wr_lane_n[g]) begin
				mem[wr_addr] <= wr_data[LO +: lwsp_pkg::LANE_W];
			end
		end

		always_ff @(posedge mclk or negedge arst_n) begin
			if (!arst_n) begin
				rd_data_q[LO +: lwsp_pkg::LANE_W] <= lwsp_pkg::DATA_RST[LO +: lwsp_pkg::LANE_W];
			end else if (rd_en) begin
				rd_data_q[LO +: lwsp_pkg::LANE_W] <= mem[rd_addr];
			end
		end
	end

endmodule

// >>> verilog/lwsp_pkg.sv
package lwsp_pkg;

	// ----------------------------------------
	// Array geometry
	// ----------------------------------------
	localparam int LANES = 4;
	localparam int LANE_W = 9;
	localparam int DATA_W = LANES * LANE_W;
	localparam int ADDR_W = 18;
	localparam int BURST_W = 2;
	localparam int UPPER_W = ADDR_W - BURST_W;
	localparam int DEPTH = 1 << ADDR_W;

	// ----------------------------------------
	// Timing, in command edges
	// ----------------------------------------
	localparam int PIPE_LATENCY = 2;
	localparam int FLOW_LATENCY = 1;

	// ----------------------------------------
	// Values after reset
	// ----------------------------------------
	localparam logic [BURST_W-1:0] BURST_RST = 2'h0;
	localparam logic [UPPER_W-1:0] UPPER_RST = 16'h0000;
	localparam logic [DATA_W-1:0] DATA_RST = 36'h0_0000_0000;

	// ----------------------------------------
	// Burst kind, Gray coded along deselect, read, write
	// ----------------------------------------
	typedef enum logic [1:0] {
		LWSP_DESEL = 2'h0,
		LWSP_READ = 2'h1,
		LWSP_WRITE = 2'h3
	} lwsp_kind_e;

	// One write waiting for its late data
	typedef struct packed {
		logic valid;
		logic [ADDR_W-1:0] addr;
		logic [LANES-1:0] lane_n;
	} lwsp_wr_s;

	localparam lwsp_wr_s WR_RST = '{valid: 1'b0, addr: 18'h0_0000, lane_n: 4'hF};

endpackage

// >>> verilog/lwsp_top.sv
`timescale 1ns/1ps
// How it works
// - Inputs are sampled only on rising mclk
// - Sleep and output enable act without clock
// - Output enable high always floats data pins
// - Writes start at an edge, no strobe
// - Pipeline reads leave through an output register
// - Two low address bits preload burst counter
// - Each lane has its own low write select
// - Lanes are nine bits, select covers all
// - Store select low writes, high reads
// - Chip selects: low, high, low active
// - All three selects needed; any one deselects
// - Clock gate high suspends everything, state held
// - Sleep request high powers the block down
// - Bypass low is flow-through, high pipelined
// - Linear order low is linear, else interleaved
// - Read starts on load with full select
// - Write recognised on select, gate, store low
// - Lane selects pick any set of lanes
// - Write with no lanes changes nothing
// - Pipeline write data comes at third edge
// - Reads and writes follow back to back
// - Flow-through read data follows one edge sooner
// - Flow-through write data comes at second edge
// - Step high advances the burst counter
// - Linear burst wraps after four addresses
module lwsp_top (
	// Clock and reset
	input wire logic mclk,
	input wire logic arst_n,
	// Address
	input wire logic [lwsp_pkg::UPPER_W-1:0] addr_upper,
	input wire logic [lwsp_pkg::BURST_W-1:0] burst_start_bits,
	// Command
	input wire logic counter_step_not_load,
	input wire logic store_select_n,
	input wire logic chip_select_one_n,
	input wire logic chip_select_two,
	input wire logic chip_select_three_n,
	input wire logic clock_gate_n,
	// Byte lane write selects
	input wire logic lane0_write_n,
	input wire logic lane1_write_n,
	input wire logic lane2_write_n,
	input wire logic lane3_write_n,
	// Data pins, split into in, out and enable
	input wire logic [lwsp_pkg::DATA_W-1:0] dq_in,
	output logic [lwsp_pkg::DATA_W-1:0] dq_out,
	output logic dq_oe_n,
	// Asynchronous controls
	input wire logic output_enable_n,
	input wire logic sleep_request,
	// Straps
	input wire logic pipe_bypass_n,
	input wire logic linear_order_n,
	// Status
	output logic power_down
);

	// ----------------------------------------
	// Qualifiers
	// ----------------------------------------
	logic active;
	logic selected;
	logic load;
	logic pipelined;
	logic [lwsp_pkg::LANES-1:0] lane_n;

	// Sleep freezes the block like a gated clock does
	assign active = !clock_gate_n && !sleep_request;
	assign selected = !chip_select_one_n && chip_select_two && !chip_select_three_n;
	assign load = !counter_step_not_load;
	assign pipelined = pipe_bypass_n;
	assign lane_n = {lane3_write_n, lane2_write_n, lane1_write_n, lane0_write_n};
	assign power_down = sleep_request;

	// ----------------------------------------
	// Burst kind state
	// ----------------------------------------
	lwsp_pkg::lwsp_kind_e kind_q;
	lwsp_pkg::lwsp_kind_e kind_d;
	lwsp_pkg::lwsp_kind_e load_kind;

	// A deselect can only continue as a deselect
	assign load_kind = !selected ? lwsp_pkg::LWSP_DESEL :
		(store_select_n ? lwsp_pkg::LWSP_READ : lwsp_pkg::LWSP_WRITE);

	always_comb begin
		case (kind_q)
			lwsp_pkg::LWSP_DESEL: begin
				kind_d = load ? load_kind : lwsp_pkg::LWSP_DESEL;
			end
			lwsp_pkg::LWSP_READ: begin
				kind_d = load ? load_kind : lwsp_pkg::LWSP_READ;
			end
			lwsp_pkg::LWSP_WRITE: begin
				kind_d = load ? load_kind : lwsp_pkg::LWSP_WRITE;
			end
			default: begin
				kind_d = lwsp_pkg::LWSP_DESEL;
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			kind_q <= lwsp_pkg::LWSP_DESEL;
		end else if (active) begin
			kind_q <= kind_d;
		end
	end

	// ----------------------------------------
	// Command decode
	// ----------------------------------------
	logic cmd_rd;
	logic cmd_wr;

	assign cmd_rd = active && (kind_d == lwsp_pkg::LWSP_READ);
	assign cmd_wr = active && (kind_d == lwsp_pkg::LWSP_WRITE);

	// ----------------------------------------
	// Address generation
	// ----------------------------------------
	logic [lwsp_pkg::UPPER_W-1:0] upper_q;
	logic [lwsp_pkg::BURST_W-1:0] low_bits;
	logic [lwsp_pkg::ADDR_W-1:0] cur_addr;

	lwsp_burst_ctr u_ctr (
		.mclk(mclk),
		.arst_n(arst_n),
		.active(active),
		.load(load),
		.linear(!linear_order_n),
		.start(burst_start_bits),
		.bits(low_bits)
	);

	// Upper bits stay put for the length of a burst
	assign cur_addr = {(load ? addr_upper : upper_q), low_bits};

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			upper_q <= lwsp_pkg::UPPER_RST;
		end else if (active && load) begin
			upper_q <= addr_upper;
		end
	end

	// ----------------------------------------
	// Write pipeline
	// ----------------------------------------
	lwsp_pkg::lwsp_wr_s wr1_q;
	lwsp_pkg::lwsp_wr_s wr2_q;
	lwsp_pkg::lwsp_wr_s wr_new;
	lwsp_pkg::lwsp_wr_s wr_due;

	assign wr_new = '{valid: cmd_wr, addr: cur_addr, lane_n: lane_n};
	// Data lands one edge after the command in flow-through, two in pipeline
	assign wr_due = pipelined ? wr2_q : wr1_q;

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			wr1_q <= lwsp_pkg::WR_RST;
			wr2_q <= lwsp_pkg::WR_RST;
		end else if (active) begin
			wr1_q <= wr_new;
			wr2_q <= wr1_q;
		end
	end

	// ----------------------------------------
	// Read pipeline and memory
	// ----------------------------------------
	logic [lwsp_pkg::DATA_W-1:0] core_q;
	logic [lwsp_pkg::DATA_W-1:0] out_q;
	logic rd1_q;
	logic rd2_q;
	logic drive;

	// A read of a word whose late write is still in flight sees the old word;
	// the controller owns that ordering, as with any late-write part
	lwsp_core u_core (
		.mclk(mclk),
		.arst_n(arst_n),
		.rd_en(cmd_rd),
		.rd_addr(cur_addr),
		.rd_data_q(core_q),
		.wr_en(active && wr_due.valid),
		.wr_addr(wr_due.addr),
		.wr_lane_n(wr_due.lane_n),
		.wr_data(dq_in)
	);

	always_ff @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			out_q <= lwsp_pkg::DATA_RST;
			rd1_q <= 1'b0;
			rd2_q <= 1'b0;
		end else if (active) begin
			out_q <= core_q;
			rd1_q <= cmd_rd;
			rd2_q <= rd1_q;
		end
	end

	assign dq_out = pipelined ? out_q : core_q;
	assign drive = pipelined ? rd2_q : rd1_q;

	// ----------------------------------------
	// Output drivers
	// ----------------------------------------
	// Enable and sleep bypass all flops so they act at once
	assign dq_oe_n = !(drive && !output_enable_n && !sleep_request);

endmodule
